// file: msim_top.sv
// Purpose: Master status word and interrupt mask behind an APB slave
// Assumes: Block events arrive as pclk pulses, pins pass msim_sync
// Notes:   Zero wait states; unmapped addresses answer pslverr
//
// Summary of operation
// R1: HDLC change with its enable set raises status bit 3.
// R2: HDLC bit clears only when the HDLC status register is read.
// R3: New verified far-end codeword raises status bit 4.
// R4: Tributary LOF or AIS change with enable raises status bit 5.
// R5: Tributary RAI change with enable bit 7 raises status bit 6.
// R6: Bit 8 follows any active loopback command on any line.
// R7: Enabled high-rate framer change raises bit 9; register read clears.
// R8: Bit 10 set after the transmit clock stays still for 200 ns.
// R9: Bit 11 set after the receive clock stays still for 200 ns.
// R10: Both clock loss bits set at reset, cleared once clocks run.
// R11: Bit 12 shows the line standard pin, never interrupts.
// R12: Bit 13 shows the alternate mux pin, never interrupts.
// R13: Mask bits 0-6 and 8-11 pass same status bit; 1 unmasks.
// R14: Mask is a 16-bit read-write register reset to zero.
// R15: Far-end interrupt holds until its status register is read.
// R16: Software writes zeros to factory test bits 0 to 5.
// R17: Bit 0 latches each one-second tick; status read clears it.
// R18: Bit 1 latches counter saturation; status read clears it.
// R19: Enabled BERT change raises bit 2; BERT status read clears.
// R20: Interrupt asserted while any status bit and its mask are one.
`timescale 1ns/1ps
`include "msim_defines.svh"
module msim_top #(
    parameter int AW          = 12,
    parameter int NUM_LINES   = 7,
    parameter int LOSS_CYCLES = `MSIM_LOSS_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [AW-1:0]        paddr,
    input  wire msim_pkg::msim_data_t pwdata,
    output msim_pkg::msim_data_t      prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 one_second_tick,
    input  wire logic                 counter_saturated,
    input  wire logic                 bert_change,
    input  wire logic                 bert_irq_enable,
    input  wire logic                 bert_status_read,
    input  wire logic                 hdlc_change,
    input  wire logic                 link_ctrl_irq_enable,
    input  wire logic                 link_ctrl_status_reg_read,
    input  wire logic                 far_alarm_codeword,
    input  wire logic                 far_alarm_status_reg_read,
    input  wire logic                 tributary_lof_ais_change,
    input  wire logic                 tributary_lof_ais_enable,
    input  wire logic                 tributary_lof_ais_read,
    input  wire logic                 tributary_rai_change,
    input  wire logic                 tributary_rai_enable,
    input  wire logic                 tributary_rai_read,
    input  wire logic [NUM_LINES-1:0] low_rate_loopback_seen,
    input  wire logic                 high_rate_framer_change,
    input  wire logic                 high_rate_framer_enable,
    input  wire logic                 high_rate_framer_read,
    input  wire logic                 formatter_tx_clock,
    input  wire logic                 line_rx_clock,
    input  wire logic                 line_standard_select_pin,
    input  wire logic                 alt_mux_select_pin,
    output logic                      irq_n,
    output logic [5:0]                factory_test_bits
);
    import msim_pkg::*;

    localparam msim_word_t STICKY   = `MSIM_STICKY_BITS;
    localparam msim_word_t MASK_WR  = `MSIM_MASK_WRITABLE;
    localparam msim_word_t TEST_WR  = `MSIM_TEST_WRITABLE;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    msim_word_t interrupt_mask;
    msim_word_t factory_test;
    msim_word_t master_status;
    msim_word_t sticky_status;
    msim_word_t live_status;
    msim_word_t set_vec;
    msim_word_t clr_vec;
    msim_word_t read_snap;
    msim_word_t next_read;
    msim_sel_t  sel;
    logic [3:0] pin_sync;
    logic       loopback;
    logic       setup;
    logic       done;
    logic       status_read;

    msim_mon_if mon_tx ();
    msim_mon_if mon_rx ();

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and clock watchers

    // Clocks and mode pins pass two flops first
    msim_sync #(.WIDTH(4)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({alt_mux_select_pin, line_standard_select_pin,
                    line_rx_clock, formatter_tx_clock}),
        .sync_out (pin_sync)
    );

    assign mon_tx.level = pin_sync[0];
    assign mon_rx.level = pin_sync[1];

    // Transmit clock watcher, sampled by pclk
    msim_clk_watch #(.LOSS_CYCLES(LOSS_CYCLES)) u_watch_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .mon     (mon_tx.watch)
    );

    // Receive clock watcher, sampled by pclk
    msim_clk_watch #(.LOSS_CYCLES(LOSS_CYCLES)) u_watch_rx (
        .pclk    (pclk),
        .presetn (presetn),
        .mon     (mon_rx.watch)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    // Setup and completion phases of a transfer
    assign setup = psel & ~penable;
    assign done  = psel & penable & pready;

    // Address decode; address bits above bit 9 must be zero
    always_comb begin
        sel = MSIM_SEL_NONE;
        if (paddr[AW-1:10] == '0) begin
            unique case (paddr[9:0])
                `MSIM_ADDR_STATUS: sel = MSIM_SEL_STATUS;
                `MSIM_ADDR_MASK:   sel = MSIM_SEL_MASK;
                `MSIM_ADDR_TEST:   sel = MSIM_SEL_TEST;
                default:           sel = MSIM_SEL_NONE;
            endcase
        end
    end

    // Read mux, snapshotted in the setup cycle
    always_comb begin
        unique case (sel)
            MSIM_SEL_STATUS: next_read = master_status;
            MSIM_SEL_MASK:   next_read = interrupt_mask;
            MSIM_SEL_TEST:   next_read = factory_test;
            MSIM_SEL_NONE:   next_read = '0;
        endcase
    end

    // Status read completes: clears bits 0 and 1 only if software saw them
    assign status_read = done & ~pwrite & (sel == MSIM_SEL_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // APB answer

    // Ready one cycle after setup, so no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pready <= 1'b0;
        else          pready <= setup;
    end

    // Unmapped address answers with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pslverr <= 1'b0;
        else          pslverr <= setup & (sel == MSIM_SEL_NONE);
    end

    // Read data, upper half reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)            read_snap <= '0;
        else if (setup & ~pwrite) read_snap <= next_read;
        else if (done)           read_snap <= '0;
    end
    assign prdata = {16'h0000, read_snap};

    ////////////////////////////////////////////////////////////////////////
    // Writable registers

    // Interrupt mask, undefined bits held at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_mask <= `MSIM_MASK_RESET;                // [R14]
        end else if (done & pwrite & (sel == MSIM_SEL_MASK)) begin
            interrupt_mask <= pwdata[15:0] & MASK_WR;          // [R13]
        end
    end

    // Factory test bits, only 0 to 5 stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factory_test <= `MSIM_TEST_RESET;
        end else if (done & pwrite & (sel == MSIM_SEL_TEST)) begin
            factory_test <= pwdata[15:0] & TEST_WR;            // [R16]
        end
    end
    assign factory_test_bits = factory_test[5:0];

    ////////////////////////////////////////////////////////////////////////
    // Status sources

    // Set conditions of the latched bits
    always_comb begin
        set_vec = '0;
        set_vec[`MSIM_BIT_OST]     = one_second_tick;            // [R17]
        set_vec[`MSIM_BIT_COUNTER_SATURATED]    = counter_saturated;          // [R18]
        set_vec[`MSIM_BIT_BERT]    = bert_change & bert_irq_enable; // [R19]
        set_vec[`MSIM_BIT_HDLC]    = hdlc_change
                                     & link_ctrl_irq_enable;     // [R1]
        set_vec[`MSIM_BIT_FAR]     = far_alarm_codeword;         // [R3]
        set_vec[`MSIM_BIT_LOF_AIS] = tributary_lof_ais_change
                                     & tributary_lof_ais_enable; // [R4]
        set_vec[`MSIM_BIT_RAI]     = tributary_rai_change
                                     & tributary_rai_enable;     // [R5]
        set_vec[`MSIM_BIT_FRAMER]  = high_rate_framer_change
                                     & high_rate_framer_enable;  // [R7]
    end

    // Clear conditions of the latched bits
    always_comb begin
        clr_vec = '0;
        clr_vec[`MSIM_BIT_OST]     = status_read
                                     & read_snap[`MSIM_BIT_OST];  // [R17]
        clr_vec[`MSIM_BIT_COUNTER_SATURATED]    = status_read
                                     & read_snap[`MSIM_BIT_COUNTER_SATURATED]; // [R18]
        clr_vec[`MSIM_BIT_BERT]    = bert_status_read;           // [R19]
        clr_vec[`MSIM_BIT_HDLC]    = link_ctrl_status_reg_read;  // [R2]
        clr_vec[`MSIM_BIT_FAR]     = far_alarm_status_reg_read;  // [R15]
        clr_vec[`MSIM_BIT_LOF_AIS] = tributary_lof_ais_read;     // [R4]
        clr_vec[`MSIM_BIT_RAI]     = tributary_rai_read;         // [R5]
        clr_vec[`MSIM_BIT_FRAMER]  = high_rate_framer_read;      // [R7]
    end

    // One latch per sticky bit; set wins over a same-cycle clear
    for (genvar i = 0; i < 16; i++) begin : g_bit
        if (STICKY[i]) begin : g_latch
            logic flag;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)        flag <= 1'b0;
                else if (set_vec[i]) flag <= 1'b1;
                else if (clr_vec[i]) flag <= 1'b0;
            end
            assign sticky_status[i] = flag;
        end else begin : g_none
            assign sticky_status[i] = 1'b0;
        end
    end

    // Loopback summary follows the lines one pclk cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) loopback <= 1'b0;
        else          loopback <= |low_rate_loopback_seen;     // [R6]
    end

    // Real-time bits
    always_comb begin
        live_status = '0;
        live_status[`MSIM_BIT_LOOP]    = loopback;              // [R6]
        live_status[`MSIM_BIT_LOST_TX] = mon_tx.lost;           // [R8]
        live_status[`MSIM_BIT_LOST_RX] = mon_rx.lost;           // [R9]
        live_status[`MSIM_BIT_STD_PIN] = pin_sync[2];           // [R11]
        live_status[`MSIM_BIT_ALT_PIN] = pin_sync[3];           // [R12]
    end

    assign master_status = sticky_status | live_status;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt

    // Active low, pins bits never unmasked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_n <= 1'b1;
        else          irq_n <= ~|(master_status & interrupt_mask); // [R20]
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_hdlc_set: assert property ( // [R1]
        hdlc_change && link_ctrl_irq_enable |=> master_status[3])
        else $error("HDLC change did not set status bit");
    chk_hdlc_hold: assert property ( // [R2]
        master_status[3] && !link_ctrl_status_reg_read |=> master_status[3])
        else $error("HDLC bit dropped without a status read");
    chk_far_set: assert property ( // [R3]
        far_alarm_codeword |=> master_status[4])
        else $error("far-end codeword did not set status bit");
    chk_far_hold: assert property ( // [R15]
        master_status[4] && !far_alarm_status_reg_read
        |=> master_status[4] && (!$past(interrupt_mask[4]) || !irq_n))
        else $error("far-end interrupt released without a read");
    chk_lof_set: assert property ( // [R4]
        tributary_lof_ais_change && tributary_lof_ais_enable
        |=> master_status[5])
        else $error("tributary LOF/AIS change lost");
    chk_rai_gate: assert property ( // [R5]
        tributary_rai_change && !tributary_rai_enable && !master_status[6]
        |=> !master_status[6])
        else $error("RAI change set bit with enable clear");
    chk_loop_follow: assert property ( // [R6]
        (|low_rate_loopback_seen) |=> master_status[8] ##0
        ((|$past(low_rate_loopback_seen)) == master_status[8]))
        else $error("loopback bit does not follow the lines");
    chk_framer_clear: assert property ( // [R7]
        high_rate_framer_read && !set_vec[9] |=> !master_status[9])
        else $error("framer bit not cleared by its read");
    chk_pin_level: assert property ( // [R11]
        $stable(line_standard_select_pin) [*3]
        |-> master_status[12] == line_standard_select_pin)
        else $error("status bit 12 differs from the pin");
    chk_pin_noirq: assert property ( // [R12]
        (master_status & interrupt_mask & 16'hCFFF) == 16'h0000 |=> irq_n)
        else $error("pin mirror bits raised the interrupt");
    chk_mask_write: assert property ( // [R13]
        done && pwrite && sel == MSIM_SEL_MASK
        |=> interrupt_mask == ($past(pwdata[15:0]) & 16'h0F7F))
        else $error("mask write stored the wrong value");
    chk_ost_clear: assert property ( // [R17]
        status_read && read_snap[0] && !one_second_tick
        |=> !master_status[0])
        else $error("tick bit not cleared by status read");
    chk_counter_saturated_keep: assert property ( // [R18]
        counter_saturated |=> master_status[1] ##1
        (master_status[1] || $past(status_read)))
        else $error("saturation event lost");
    chk_bert_set: assert property ( // [R19]
        bert_change && bert_irq_enable |=> master_status[2])
        else $error("BERT change did not set status bit");
    chk_irq_match: assert property ( // [R20]
        ##1 irq_n == !(|($past(master_status) & $past(interrupt_mask))))
        else $error("interrupt output disagrees with masked status");
endmodule : msim_top

// file: msim_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 250 MHz register clock, APB word addressing
// Notes:   Byte address of each register is four times its index
`ifndef MSIM_DEFINES_SVH
`define MSIM_DEFINES_SVH

// Register indices and their byte addresses
`define MSIM_IDX_STATUS     8'h08
`define MSIM_IDX_MASK       8'h0A
`define MSIM_IDX_TEST       8'h0C
`define MSIM_ADDR_STATUS    ({`MSIM_IDX_STATUS, 2'b00})
`define MSIM_ADDR_MASK      ({`MSIM_IDX_MASK, 2'b00})
`define MSIM_ADDR_TEST      ({`MSIM_IDX_TEST, 2'b00})

// Master status bit positions
`define MSIM_BIT_OST        0
`define MSIM_BIT_COUNTER_SATURATED       1
`define MSIM_BIT_BERT       2
`define MSIM_BIT_HDLC       3
`define MSIM_BIT_FAR        4
`define MSIM_BIT_LOF_AIS    5
`define MSIM_BIT_RAI        6
`define MSIM_BIT_LOOP       8
`define MSIM_BIT_FRAMER     9
`define MSIM_BIT_LOST_TX    10
`define MSIM_BIT_LOST_RX    11
`define MSIM_BIT_STD_PIN    12
`define MSIM_BIT_ALT_PIN    13

// Field sets and reset values
`define MSIM_STICKY_BITS    16'h027F
`define MSIM_MASK_WRITABLE  16'h0F7F
`define MSIM_TEST_WRITABLE  16'h003F
`define MSIM_MASK_RESET     16'h0000
`define MSIM_TEST_RESET     16'h0000

// Clock loss timing
`define MSIM_PCLK_PERIOD_NS 4
`define MSIM_LOSS_TIME_NS   200
`define MSIM_LOSS_CYCLES    ((`MSIM_LOSS_TIME_NS + `MSIM_PCLK_PERIOD_NS - 1) \
                             / `MSIM_PCLK_PERIOD_NS)

`endif

// file: msim_pkg.sv
// Purpose: Types shared by the master status block
// Assumes: 32-bit APB data, 16-bit registers
// Notes:   Numeric constants live in msim_defines.svh
package msim_pkg;
    typedef logic [31:0] msim_data_t;
    typedef logic [15:0] msim_word_t;

    // Register selected by the current bus address
    typedef enum logic [1:0] {
        MSIM_SEL_NONE   = 2'b00,
        MSIM_SEL_STATUS = 2'b01,
        MSIM_SEL_MASK   = 2'b10,
        MSIM_SEL_TEST   = 2'b11
    } msim_sel_t;
endpackage : msim_pkg

// file: msim_mon_if.sv
// Purpose: Link between the top and one line clock watcher
// Assumes: Level already synchronised to pclk
// Notes:   One instance per watched clock
`timescale 1ns/1ps
interface msim_mon_if;
    logic level;
    logic lost;
    modport watch (input level, output lost);
    modport user  (output level, input lost);
endinterface : msim_mon_if

// file: msim_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are slow levels or clocks below pclk/2
// Notes:   Only the second stage is read outside
`timescale 1ns/1ps
module msim_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // Two stages, both cleared on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : msim_sync

// file: msim_clk_watch.sv
// Purpose: Flags a line clock that has stopped toggling
// Assumes: Watched clock sampled through msim_sync
// Notes:   Loss declared after a quiet spell of LOSS_CYCLES
`timescale 1ns/1ps
`include "msim_defines.svh"
module msim_clk_watch #(
    parameter int LOSS_CYCLES = `MSIM_LOSS_CYCLES
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    msim_mon_if.watch  mon
);
    import msim_pkg::*;
    localparam int CW = $clog2(LOSS_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(LOSS_CYCLES - 1);

    logic          prev_level;
    logic          toggle;
    logic [CW-1:0] quiet_cnt;
    logic          lost;

    assign toggle   = mon.level ^ prev_level;
    assign mon.lost = lost;

    // Edge memory of the watched clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prev_level <= 1'b0;
        else          prev_level <= mon.level;
    end

    // Quiet time counter, restarted by any toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)              quiet_cnt <= '0;
        else if (toggle)           quiet_cnt <= '0;
        else if (quiet_cnt != LAST) quiet_cnt <= quiet_cnt + CW'(1);
    end

    // Loss flag: set at reset, cleared by toggling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                lost <= 1'b1;       // [R10]
        else if (toggle)             lost <= 1'b0;       // [R8] [R9]
        else if (quiet_cnt == LAST)  lost <= 1'b1;       // [R8] [R9]
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_loss_clear: assert property (toggle |=> !lost) // [R8]
        else $error("loss flag stayed set after a clock toggle");
    chk_loss_set: assert property ( // [R9]
        (quiet_cnt == LAST) && !toggle |=> lost)
        else $error("loss flag not set after quiet spell");
endmodule : msim_clk_watch

// file: msim_host.sv
// Purpose: APB host that reaches the master status registers
// Assumes: Called right after a rising edge of pclk
// Notes:   Holds each request until pready is seen high
`timescale 1ns/1ps
module msim_host (
    input  wire logic                 pclk,
    input  wire msim_pkg::msim_data_t prdata,
    input  wire logic                 pready,
    input  wire logic                 pslverr,
    output logic                      psel,
    output logic                      penable,
    output logic                      pwrite,
    output logic [11:0]               paddr,
    output msim_pkg::msim_data_t      pwdata
);
    import msim_pkg::*;
    // Bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end
    // One transfer: setup, then access until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input msim_data_t d, output msim_data_t q,
                        output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : msim_host

// file: testbench.sv
// Purpose: Self-checking bench for the master status block
// Assumes: Loss count shortened to 8 cycles
// Notes:   Line clocks run at 50 MHz and stand still when stopped
`timescale 1ns/1ps
`include "msim_defines.svh"
module testbench;
    import msim_pkg::*;
    localparam logic [11:0] A_ST = 12'(`MSIM_ADDR_STATUS);
    localparam logic [11:0] A_MK = 12'(`MSIM_ADDR_MASK);
    localparam logic [11:0] A_TS = 12'(`MSIM_ADDR_TEST);
    localparam int BP [6] = '{2, 3, 4, 5, 6, 9};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq_n;
    logic [11:0] paddr;
    msim_data_t pwdata, prdata;
    logic [13:0] pv = '0;
    logic en = 1'b0;
    logic [6:0] lines = '0;
    logic [1:0] run = '0;
    logic [1:0] pins = '0;
    logic ftx = 1'b0;
    logic frx = 1'b0;
    logic [5:0] ftb;
    int n_fail = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////
    // Clocks: pclk free, line clocks only while running
    always #2 pclk = ~pclk;
    always #10 if (run[0]) ftx <= ~ftx;
    always #10 if (run[1]) frx <= ~frx;
    msim_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    msim_top #(.LOSS_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .one_second_tick(pv[12]),
        .counter_saturated(pv[13]), .bert_change(pv[0]),
        .bert_irq_enable(en), .bert_status_read(pv[6]),
        .hdlc_change(pv[1]), .link_ctrl_irq_enable(en),
        .link_ctrl_status_reg_read(pv[7]), .far_alarm_codeword(pv[2]),
        .far_alarm_status_reg_read(pv[8]),
        .tributary_lof_ais_change(pv[3]), .tributary_lof_ais_enable(en),
        .tributary_lof_ais_read(pv[9]), .tributary_rai_change(pv[4]),
        .tributary_rai_enable(en), .tributary_rai_read(pv[10]),
        .low_rate_loopback_seen(lines), .high_rate_framer_change(pv[5]),
        .high_rate_framer_enable(en), .high_rate_framer_read(pv[11]),
        .formatter_tx_clock(ftx), .line_rx_clock(frx),
        .line_standard_select_pin(pins[0]), .alt_mux_select_pin(pins[1]),
        .irq_n(irq_n), .factory_test_bits(ftb));
    ////////////////////////////////////////////////////////////////////
    // Compare, count, report
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        checked++;
        if (g !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic wt(int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    // One-cycle pulse on event or clear input i
    task automatic pulse(int i);
        @(posedge pclk);
        pv[i] <= 1'b1;
        @(posedge pclk);
        pv[i] <= 1'b0;
    endtask : pulse
    // Read master status and compare one bit
    task automatic st(int b, logic x, string nm);
        msim_data_t q;
        logic e;
        u_host.xfer(1'b0, A_ST, 32'h0, q, e);
        chk(nm, 32'(x), 32'(q[b]));
    endtask : st
    task automatic test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        #60000;
        n_fail++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        msim_data_t q;
        logic e;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        st(10, 1'b1, "lost_tx_reset");
        st(11, 1'b1, "lost_rx_reset");
        run <= 2'b11;
        wt(20);
        st(10, 1'b0, "lost_tx_run");
        st(11, 1'b0, "lost_rx_run");
        for (int c = 0; c < 2; c++) begin
            run[c] <= 1'b0;
            wt(20);
            st(10 + c, 1'b1, "clock_lost");
            st(11 - c, 1'b0, "other_clock");
            run[c] <= 1'b1;
            wt(20);
            st(10 + c, 1'b0, "clock_back");
        end
        u_host.xfer(1'b0, A_MK, 32'h0, q, e);
        chk("mask_reset", 32'h0000_0000, q);
        u_host.xfer(1'b1, A_MK, 32'hFFFF_FFFF, q, e);
        u_host.xfer(1'b0, A_MK, 32'h0, q, e);
        chk("mask_rw", 32'(`MSIM_MASK_WRITABLE), q);
        u_host.xfer(1'b1, A_TS, 32'h0, q, e);
        u_host.xfer(1'b0, A_TS, 32'h0, q, e);
        chk("test_reg", 32'h0000_0000, q);
        chk("test_bits", 32'h0000_0000, 32'(ftb));
        u_host.xfer(1'b0, 12'h004, 32'h0, q, e);
        chk("unmapped", 32'h0000_0001, 32'(e));
        pins <= 2'b11;
        wt(4);
        u_host.xfer(1'b0, A_ST, 32'h0, q, e);
        chk("pins", 32'h0000_0003, 32'(q[13:12]));
        chk("pins_irq", 32'h0000_0001, 32'(irq_n));
        lines <= 7'h40;
        wt(3);
        st(8, 1'b1, "loop_on");
        chk("loop_irq", 32'h0000_0000, 32'(irq_n));
        lines <= 7'h00;
        wt(3);
        st(8, 1'b0, "loop_off");
        wt(2);
        chk("loop_irq_off", 32'h0000_0001, 32'(irq_n));
        for (int i = 0; i < 6; i++) begin
            u_host.xfer(1'b1, A_MK, 32'h0, q, e);
            en <= 1'b0;
            pulse(i);
            wt(2);
            st(BP[i], i == 2, "change_off");
            pulse(6 + i);
            en <= 1'b1;
            pulse(i);
            wt(2);
            st(BP[i], 1'b1, "change_on");
            st(BP[i], 1'b1, "held");
            chk("masked", 32'h0000_0001, 32'(irq_n));
            u_host.xfer(1'b1, A_MK, 32'h1 << BP[i], q, e);
            wt(2);
            chk("unmasked", 32'h0000_0000, 32'(irq_n));
            pulse(6 + i);
            wt(3);
            st(BP[i], 1'b0, "cleared");
            chk("released", 32'h0000_0001, 32'(irq_n));
        end
        for (int i = 0; i < 2; i++) begin
            pulse(12 + i);
            wt(2);
            st(i, 1'b1, "event_set");
            st(i, 1'b0, "event_clear");
        end
        test_done();
    end
endmodule : testbench
